// File: core/fbod_host.sv
// Purpose : Host-side controller that drives a parallel flash through its pins
// Assumes : Flash pins are synchronous to core_clk; one operation at a time
// Notes   : Idle bus leaves the flash in standby with data lines released
//
// Overview of operation
// [R1] Flash keeps commands in an unmapped latch; host only writes cycles.
// [R2] Host drives 22-bit word address; top seven bits pick the sector.
// [R3] Read: select and output gate low, write strobe and reset high.
// [R4] Flash drives data only with output gate low; host releases lines then.
// [R5] Write: strobe and select low, output gate held high.
// [R6] Flash starts in read-array after power-up or reset pulse.
// [R7] Flash stays in read-array until a write changes its latch.
// [R8] Short program mode needs two write cycles per word.
// [R9] Flash erases one sector, several, or all.
// [R10] High voltage on fast program pin: short mode, unprotect, fast program.
// [R11] Fast program voltage only during accelerated programming, then removed.
// [R12] Identify mode returns codes on low eight data lines.
// [R13] Standby floats flash outputs regardless of output gate.
// [R14] Standby when select and reset both high.
// [R15] After standby, read data valid only after select access time.
// [R16] Deselecting during embedded operation does not stop it.
// [R17] Automatic sleep after stable address for access time plus 30 ns.
// [R18] Sleep keeps last data; new address gives data after access time.
// [R19] Edge sector lock low keeps first or last sector protected.
// [R20] Protect: reset at high voltage, write levels, lock high, A6/A1/A0 code.
// [R21] Sectors ship unprotected; identification sector may be protected.
// [R22] Reset low aborts, floats outputs, ignores cycles, returns to read-array.
// [R23] High-voltage levels are separate qualifier signals.
`timescale 1ns/1ps

module fbod_host (
    input  wire logic                            core_clk,
    input  wire logic                            reset,
    input  wire logic                            req_valid,
    input  wire fbod_pkg::fbod_req_t             req,
    output logic                                 req_ready,
    output logic                                 rsp_valid,
    output logic [fbod_pkg::DATA_W-1:0]          rsp_data,
    output fbod_pkg::fbod_ctl_t                  ctl,
    output logic [fbod_pkg::ADDR_W-1:0]          word_address,
    input  wire logic [fbod_pkg::DATA_W-1:0]     data_lines_i,
    output logic [fbod_pkg::DATA_W-1:0]          data_lines_o,
    output logic                                 data_lines_oe_n
);

    // ---------------------------------------------------------------
    // Request decode
    // ---------------------------------------------------------------
    fbod_pkg::fbod_state_t           state_q, state_d;
    fbod_pkg::fbod_req_t             cur_q;
    logic [fbod_pkg::CNT_W-1:0]      cnt_q, cnt_d;
    fbod_pkg::fbod_ctl_t             ctl_d;

    function automatic logic [fbod_pkg::ADDR_W-1:0] fbod_prot_addr(
        input logic [fbod_pkg::ADDR_W-1:0] a,
        input logic                        unprot);
        logic [fbod_pkg::ADDR_W-1:0] code;
        code = unprot ? fbod_pkg::UNPROT_A_VAL : fbod_pkg::PROT_A_VAL;
        // Sector bits kept, low code bits forced
        fbod_prot_addr = (a & ~fbod_pkg::PROT_A_MASK) | code; // [R20] [R2]
    endfunction

    wire logic is_read   = (cur_q.op == fbod_pkg::FBOD_OP_READ);
    wire logic is_reset  = (cur_q.op == fbod_pkg::FBOD_OP_RESET);
    wire logic is_prot   = (cur_q.op == fbod_pkg::FBOD_OP_PROT) ||
                           (cur_q.op == fbod_pkg::FBOD_OP_UNPROT);
    wire logic is_tmpunp = (cur_q.op == fbod_pkg::FBOD_OP_TMPUNP);
    wire logic is_write  = !is_read && !is_reset && !is_tmpunp;
    wire logic take      = (state_q == fbod_pkg::FBOD_IDLE) && req_valid;
    wire logic cnt_end   = (cnt_q == '0);

    // Read waits the full select access time, since each read leaves standby
    wire logic [fbod_pkg::CNT_W-1:0] strobe_len =
        is_reset ? fbod_pkg::CNT_W'(fbod_pkg::RESET_CYC - 1) :
        is_read  ? fbod_pkg::CNT_W'(fbod_pkg::ACCESS_CYC - 1) : // [R15] [R18]
                   fbod_pkg::CNT_W'(fbod_pkg::WRITE_CYC - 1);

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_end ? cnt_q : cnt_q - 1'b1;
        // Idle: select and reset high puts flash in standby [R14] [R13]
        ctl_d   = '{chip_select_n: 1'b1, output_gate_n: 1'b1, write_strobe_n: 1'b1,
                    hw_reset_n: 1'b1, protect_high_voltage: 1'b0,
                    fast_program_high_voltage: 1'b0, edge_sector_lock_n: 1'b1};
        unique case (state_q)
            fbod_pkg::FBOD_IDLE: begin
                if (req_valid) begin
                    state_d = fbod_pkg::FBOD_SETUP;
                end
            end
            fbod_pkg::FBOD_SETUP: begin
                // Qualifiers settle one cycle before the strobe
                ctl_d.fast_program_high_voltage =
                    (cur_q.op == fbod_pkg::FBOD_OP_ACCEL); // [R10] [R23]
                ctl_d.protect_high_voltage = is_prot || is_tmpunp; // [R20] [R23]
                ctl_d.hw_reset_n    = !is_reset;
                ctl_d.chip_select_n = is_reset || is_tmpunp;
                state_d = fbod_pkg::FBOD_STROBE;
                cnt_d   = strobe_len;
            end
            fbod_pkg::FBOD_STROBE: begin
                ctl_d.fast_program_high_voltage =
                    (cur_q.op == fbod_pkg::FBOD_OP_ACCEL); // [R11]
                ctl_d.protect_high_voltage = is_prot || is_tmpunp;
                ctl_d.hw_reset_n     = !is_reset; // [R22] [R6]
                ctl_d.chip_select_n  = is_reset || is_tmpunp;
                ctl_d.output_gate_n  = !is_read;            // [R3] [R5]
                ctl_d.write_strobe_n = !(is_write && !is_reset); // [R5] [R1] [R7]
                if (cnt_end) begin
                    state_d = fbod_pkg::FBOD_DONE;
                end
            end
            fbod_pkg::FBOD_DONE: begin
                // Strobe lifted; high voltage removed with it [R11]
                ctl_d.hw_reset_n    = !is_reset;
                ctl_d.chip_select_n = 1'b1;
                state_d = fbod_pkg::FBOD_HOLD;
            end
            fbod_pkg::FBOD_HOLD: begin
                state_d = fbod_pkg::FBOD_IDLE;
            end
            default: begin
                state_d = fbod_pkg::FBOD_IDLE;
            end
        endcase
    end

    wire logic [fbod_pkg::ADDR_W-1:0] addr_d =
        is_prot ? fbod_prot_addr(cur_q.word_address,
                                 cur_q.op == fbod_pkg::FBOD_OP_UNPROT)
                : cur_q.word_address;

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q <= fbod_pkg::FBOD_IDLE;
            cnt_q   <= '0;
            cur_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            if (take) begin
                cur_q <= req;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctl          <= '{chip_select_n: 1'b1, output_gate_n: 1'b1,
                              write_strobe_n: 1'b1, hw_reset_n: 1'b1,
                              protect_high_voltage: 1'b0,
                              fast_program_high_voltage: 1'b0,
                              edge_sector_lock_n: 1'b1};
            word_address    <= '0;
            data_lines_o    <= '0;
            data_lines_oe_n <= 1'b1;
            req_ready       <= 1'b0;
            rsp_valid       <= 1'b0;
            rsp_data        <= '0;
        end else begin
            ctl          <= ctl_d;
            word_address <= addr_d; // [R2]
            data_lines_o <= cur_q.wdata;
            // Drive from setup through the last strobe cycle; data is released on the same edge that lifts the strobe [R4]
            data_lines_oe_n <= !(is_write && (state_q == fbod_pkg::FBOD_SETUP ||
                                              state_q == fbod_pkg::FBOD_STROBE)); // [R5]
            req_ready <= (state_d == fbod_pkg::FBOD_IDLE) && !take;
            rsp_valid <= (state_q == fbod_pkg::FBOD_DONE);
            // Sampled at the end of the access window [R12]
            if (state_q == fbod_pkg::FBOD_STROBE && cnt_end && is_read) begin
                rsp_data <= data_lines_i; // [R3]
            end
        end
    end

endmodule

// File: core/fbod_pkg.sv
// Purpose : Shared types and constants for the parallel flash bus controller
// Assumes : 250 MHz core clock, 16-bit flash with 22-bit word address
// Notes   : Access time figures are plain defaults, not taken from a speed grade
package fbod_pkg;

    // ---------------------------------------------------------------
    // Widths and timing
    // ---------------------------------------------------------------
    localparam int ADDR_W          = 22;
    localparam int DATA_W          = 16;
    localparam int SECT_LSB        = 15;
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int ACCESS_TIME_NS  = 120;
    localparam int WRITE_PULSE_NS  = 50;
    localparam int RESET_PULSE_NS  = 500;
    localparam int ACCESS_CYC      = (ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_CYC       = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RESET_CYC       = (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W           = 8;
    localparam logic [ADDR_W-1:0] PROT_A_MASK  = 22'h000043;
    localparam logic [ADDR_W-1:0] PROT_A_VAL   = 22'h000002;
    localparam logic [ADDR_W-1:0] UNPROT_A_VAL = 22'h000042;

    // ---------------------------------------------------------------
    // Operations and states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        FBOD_OP_READ    = 3'h0,
        FBOD_OP_WRITE   = 3'h1,
        FBOD_OP_ACCEL   = 3'h2,
        FBOD_OP_RESET   = 3'h3,
        FBOD_OP_PROT    = 3'h4,
        FBOD_OP_UNPROT  = 3'h5,
        FBOD_OP_TMPUNP  = 3'h6
    } fbod_op_t;

    typedef enum logic [2:0] {
        FBOD_IDLE   = 3'h0,
        FBOD_SETUP  = 3'h1,
        FBOD_STROBE = 3'h3,
        FBOD_DONE   = 3'h2,
        FBOD_HOLD   = 3'h6
    } fbod_state_t;

    typedef struct packed {
        fbod_op_t                op;
        logic [ADDR_W-1:0]       word_address;
        logic [DATA_W-1:0]       wdata;
    } fbod_req_t;

    typedef struct packed {
        logic                    chip_select_n;
        logic                    output_gate_n;
        logic                    write_strobe_n;
        logic                    hw_reset_n;
        logic                    protect_high_voltage;
        logic                    fast_program_high_voltage;
        logic                    edge_sector_lock_n;
    } fbod_ctl_t;

endpackage

// File: dv/fbod_chk.sv
// Purpose : Pin-level checks on the flash host controller
// Assumes : One clock domain, asynchronous active-high reset
// Notes   : Latencies follow the package access and write counts
`timescale 1ns/1ps
module fbod_chk (
    input wire logic                        core_clk,
    input wire logic                        reset,
    input wire logic                        req_valid,
    input wire fbod_pkg::fbod_req_t         req,
    input wire logic                        req_ready,
    input wire logic                        rsp_valid,
    input wire fbod_pkg::fbod_ctl_t         ctl,
    input wire logic [fbod_pkg::ADDR_W-1:0] word_address,
    input wire logic                        data_lines_oe_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    wire take = req_valid && req_ready;
    chk_read_levels: assert property (
        !ctl.output_gate_n |-> !ctl.chip_select_n && ctl.write_strobe_n && ctl.hw_reset_n)
        else $error("output gate low outside a read");
    chk_write_levels: assert property (
        !ctl.write_strobe_n |-> ctl.output_gate_n && !ctl.chip_select_n && !data_lines_oe_n)
        else $error("write strobe with wrong levels");
    chk_bus_release: assert property (
        !ctl.output_gate_n |-> data_lines_oe_n) else $error("host drives data during read");
    chk_reset_float: assert property (
        !ctl.hw_reset_n |-> ctl.chip_select_n && data_lines_oe_n)
        else $error("cycle during reset pulse");
    chk_fast_only: assert property (
        ctl.fast_program_high_voltage |-> ctl.output_gate_n && !ctl.protect_high_voltage)
        else $error("fast program voltage outside programming");
    chk_prot_code: assert property (
        ctl.protect_high_voltage && !ctl.write_strobe_n
        |-> word_address[1:0] == 2'b10 && ctl.edge_sector_lock_n)
        else $error("protect strobe with wrong address code");
    chk_read_time: assert property (
        take && req.op == fbod_pkg::FBOD_OP_READ |-> !rsp_valid [*8] ##26 rsp_valid)
        else $error("read answer not at full access time");
    chk_write_time: assert property (
        take && req.op == fbod_pkg::FBOD_OP_WRITE |-> ##16 rsp_valid)
        else $error("write answer late or early");
    cover property (take && req.op == fbod_pkg::FBOD_OP_READ);
    cover property (take && req.op == fbod_pkg::FBOD_OP_ACCEL);
    cover property (take && req.op == fbod_pkg::FBOD_OP_PROT);
endmodule

// File: dv/fbod_flash_model.sv
// Purpose : Behavioural flash device facing the host controller
// Assumes : Array word is a fixed function of the address
// Notes   : Resolves the shared data lines from both parties' enables
`timescale 1ns/1ps
module fbod_flash_model (
    input  wire fbod_pkg::fbod_ctl_t ctl,
    input  wire logic [21:0]         word_address,
    input  wire logic [15:0]         data_lines_o,
    input  wire logic                data_lines_oe_n,
    output logic [15:0]              data_lines_i,
    output logic [39:0]              wr_log,
    output int                       resets
);
    logic [15:0] held = 16'h0000;
    wire         rd_en = !ctl.chip_select_n && !ctl.output_gate_n && ctl.write_strobe_n
                         && ctl.hw_reset_n;
    wire  [15:0] arr = word_address[15:0] ^ 16'h5A3C;
    // Released lines show the inverse of the last word, so a stale value never matches
    assign data_lines_i = rd_en ? arr : (!data_lines_oe_n ? data_lines_o : ~held);
    initial wr_log = '0;
    initial resets = 0;
    always @(posedge rd_en) held = arr;
    // Latch follows the bus while strobe and select are low; select may rise with the strobe
    always @*
        if (!ctl.write_strobe_n && !ctl.chip_select_n) wr_log <= {ctl.fast_program_high_voltage,
            ctl.protect_high_voltage, word_address, data_lines_i};
    always @(negedge ctl.hw_reset_n) resets++;
endmodule

// File: dv/flash_bus_operation_decode_test.sv
// Purpose : Self-checking bench for the flash host controller
// Assumes : Inputs change on the falling clock edge
// Notes   : Seeded random addresses and data, with protect and reset corners
`timescale 1ns/1ps
module flash_bus_operation_decode_test;
    logic                core_clk = 0, reset = 1, req_valid = 0, req_ready, rsp_valid, oe_n;
    fbod_pkg::fbod_req_t req = '0;
    fbod_pkg::fbod_ctl_t ctl;
    logic [15:0]         rsp_data, din, dout, d;
    logic [21:0]         word_address, a;
    logic [39:0]         wr_log;
    int                  resets, fail_count = 0, samples_checked = 0, cycles = 0, seed = 32'hA602;
    always #2 core_clk = ~core_clk;
    fbod_host dut (.core_clk(core_clk), .reset(reset), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .ctl(ctl),
        .word_address(word_address), .data_lines_i(din), .data_lines_o(dout),
        .data_lines_oe_n(oe_n));
    fbod_flash_model flash (.ctl(ctl), .word_address(word_address), .data_lines_o(dout),
        .data_lines_oe_n(oe_n), .data_lines_i(din), .wr_log(wr_log), .resets(resets));
    function automatic logic [15:0] exp_word(input logic [21:0] ad);
        return ad[15:0] ^ 16'h5A3C;
    endfunction
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checked=%0d failed=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic op(input fbod_pkg::fbod_op_t o, input logic [21:0] ad, input logic [15:0] wd);
        int n;
        n = 0;
        @(negedge core_clk);
        req_valid = 1;
        req = '{o, ad, wd};
        while (req_ready !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
        req_valid = 0;
        while (rsp_valid !== 1'b1 && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        check(n < 300, 1);
    endtask
    always @(posedge core_clk)
        if (++cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    initial begin
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        reset = 0;
        check(ctl, 7'h79);
        check(oe_n, 1);
        for (int i = 0; i < 8; i++) begin
            a = $random(seed);
            d = $random(seed);
            op(fbod_pkg::FBOD_OP_WRITE, a, d);
            check(wr_log, {2'b00, a, d});
            op(fbod_pkg::FBOD_OP_READ, a, 16'h0000);
            check(rsp_data, exp_word(a));
        end
        op(fbod_pkg::FBOD_OP_ACCEL, a, d);
        check(wr_log, {2'b10, a, d});
        for (int u = 0; u < 2; u++) begin
            op(u ? fbod_pkg::FBOD_OP_UNPROT : fbod_pkg::FBOD_OP_PROT, 22'h3FFFFF, d);
            check(wr_log[39:16], {2'b01, 15'h7FFF, u[0], 6'h3E});
        end
        op(fbod_pkg::FBOD_OP_TMPUNP, 22'h000000, 16'h0000);
        check(wr_log[39:16], {2'b01, 22'h3FFFFE});
        op(fbod_pkg::FBOD_OP_RESET, 22'h000000, 16'h0000);
        check(resets, 1);
        op(fbod_pkg::FBOD_OP_READ, 22'h3F8001, 16'h0000);
        check(rsp_data, exp_word(22'h3F8001));
        report_and_stop();
    end
endmodule
bind fbod_host fbod_chk chk (.core_clk(core_clk), .reset(reset), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .ctl(ctl),
    .word_address(word_address), .data_lines_oe_n(data_lines_oe_n));
